//--- rtl/wavext_pkg.sv
package wavext_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FDEMASK = 8'h08;
  localparam logic [7:0] ADDR_FDCTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DTBOTH = 8'h18;
  localparam logic [7:0] ADDR_DTBOTHBUF = 8'h1c;
  localparam logic [7:0] ADDR_LOW_SIDE_DEAD_TIME = 8'h20;
  localparam logic [7:0] ADDR_HIGH_SIDE_DEAD_TIME = 8'h24;
  localparam logic [7:0] ADDR_DTLSBUF = 8'h28;
  localparam logic [7:0] ADDR_DTHSBUF = 8'h2c;
  localparam logic [7:0] ADDR_OUTOV = 8'h30;
  localparam logic [7:0] ADDR_PORTDIR = 8'h34;
  localparam logic [7:0] ADDR_LOCK = 8'h38;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_PGM = 5;
  localparam int CTRL_CWCM = 4;
  localparam int FD_DBD = 4;
  localparam int FD_MODE = 2;
  localparam int ST_FDF = 2;
  localparam int ST_HSV = 1;
  localparam int ST_LSV = 0;
  localparam logic [1:0] FAULT_ACTION_FIELD_NONE = 2'h0;
  localparam logic [1:0] FAULT_ACTION_FIELD_CLEARDIR = 2'h3;
  // ----------------------------------------
  // reset values and responses
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FAULT_LAT_MAX = 2;
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_FAULT = 2'b01,
    FS_WAIT_UPD = 2'b10
  } fault_state_t;
endpackage : wavext_pkg

//--- rtl/wavext.sv
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module wavext
  import wavext_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer side
  input wire logic [3:0] waveform_generator,
  input wire logic [3:0] compare_channel_output_enable,
  input wire logic update,
  // events and debug, asynchronous
  input wire logic [7:0] event_in,
  input wire logic debug_break,
  // port
  output logic [7:0] port_out,
  output logic [7:0] port_override,
  output logic [7:0] port_dir,
  output logic timer_error_flag
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {debug_break, event_in};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl_q, fdemask_q, fdctrl_q, low_side_dead_time_q, high_side_dead_time_q, dtlsbuf_q, dthsbuf_q;
  logic [7:0] outov_q, dirsw_q;
  logic lock_q, lsv_q, hsv_q, fdf_q, fault_active;
  fault_state_t fst_q;
  logic wr_en;
  logic [7:0] wa_q;
  logic [7:0] wd_q;
  logic aw_got_q, w_got_q;

  // address decode for bus responses
  logic wr_map, rd_map;
  always_comb begin
    case (wa_q)
      ADDR_CTRL, ADDR_FDEMASK, ADDR_FDCTRL, ADDR_STATUS: wr_map = 1'b1;
      ADDR_DTBOTH, ADDR_DTBOTHBUF, ADDR_LOW_SIDE_DEAD_TIME, ADDR_HIGH_SIDE_DEAD_TIME: wr_map = 1'b1;
      ADDR_DTLSBUF, ADDR_DTHSBUF, ADDR_OUTOV, ADDR_PORTDIR, ADDR_LOCK: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
    case (s_axi_araddr)
      ADDR_CTRL, ADDR_FDEMASK, ADDR_FDCTRL, ADDR_STATUS: rd_map = 1'b1;
      ADDR_DTBOTH, ADDR_DTBOTHBUF, ADDR_LOW_SIDE_DEAD_TIME, ADDR_HIGH_SIDE_DEAD_TIME: rd_map = 1'b1;
      ADDR_DTLSBUF, ADDR_DTHSBUF, ADDR_OUTOV, ADDR_PORTDIR, ADDR_LOCK: rd_map = 1'b1;
      default: rd_map = 1'b0;
    endcase
  end

  // write channel: take address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wa_q <= RST_BYTE;
      wd_q <= RST_BYTE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        wa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : RST_BYTE;
      end
      if (wr_en) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_en = aw_got_q && w_got_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // control registers, only ctrl and fault mask blocked by lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= RST_BYTE;
      fdemask_q <= RST_BYTE;
      fdctrl_q <= RST_BYTE;
      lock_q <= 1'b0;
      dirsw_q <= RST_BYTE;
    end else if (wr_en) begin
      if (!lock_q && wa_q == ADDR_CTRL) ctrl_q <= wd_q & 8'h3f;
      if (!lock_q && wa_q == ADDR_FDEMASK) fdemask_q <= wd_q;
      if (wa_q == ADDR_FDCTRL) fdctrl_q <= wd_q & 8'h17;
      if (wa_q == ADDR_LOCK) lock_q <= wd_q[0];
      if (wa_q == ADDR_PORTDIR) dirsw_q <= wd_q;
    end
  end

  // override register: writes blocked by lock or fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outov_q <= RST_BYTE;
    end else if (wr_en && wa_q == ADDR_OUTOV && !lock_q && !fault_active) begin
      outov_q <= wd_q;
    end
  end

  // double-buffered dead time / pattern
  logic upd_ok;
  assign upd_ok = update;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_side_dead_time_q <= RST_BYTE;
      high_side_dead_time_q <= RST_BYTE;
      dtlsbuf_q <= RST_BYTE;
      dthsbuf_q <= RST_BYTE;
      lsv_q <= 1'b0;
      hsv_q <= 1'b0;
    end else begin
      if (upd_ok && lsv_q) begin
        low_side_dead_time_q <= dtlsbuf_q;
        lsv_q <= 1'b0;
      end
      if (upd_ok && hsv_q) begin
        high_side_dead_time_q <= dthsbuf_q;
        hsv_q <= 1'b0;
      end
      if (wr_en) begin
        case (wa_q)
          ADDR_DTBOTH: begin
            low_side_dead_time_q <= wd_q;
            high_side_dead_time_q <= wd_q;
          end
          ADDR_LOW_SIDE_DEAD_TIME: low_side_dead_time_q <= wd_q;
          ADDR_HIGH_SIDE_DEAD_TIME: high_side_dead_time_q <= wd_q;
          ADDR_DTBOTHBUF: begin
            dtlsbuf_q <= wd_q;
            dthsbuf_q <= wd_q;
            lsv_q <= 1'b1;
            hsv_q <= 1'b1;
          end
          ADDR_DTLSBUF: begin
            dtlsbuf_q <= wd_q;
            lsv_q <= 1'b1;
          end
          ADDR_DTHSBUF: begin
            dthsbuf_q <= wd_q;
            hsv_q <= 1'b1;
          end
          ADDR_STATUS: begin
            if (wd_q[ST_LSV]) lsv_q <= 1'b0;
            if (wd_q[ST_HSV]) hsv_q <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // fault unit
  // ----------------------------------------
  logic fault_cond;
  logic fd_enabled;
  assign fd_enabled = fdctrl_q[1:0] == FAULT_ACTION_FIELD_CLEARDIR;
  assign fault_cond = fd_enabled && ((|(sync2_q[7:0] & fdemask_q))
    || (sync2_q[8] && !fdctrl_q[FD_DBD]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fdf_q <= 1'b0;
      timer_error_flag <= 1'b0;
    end else begin
      timer_error_flag <= fault_cond;
      if (fault_cond) begin
        fdf_q <= 1'b1;
      end else if (wr_en && wa_q == ADDR_STATUS && wd_q[ST_FDF]) begin
        fdf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fst_q <= FS_IDLE;
    end else begin
      case (fst_q)
        FS_IDLE: if (fault_cond) fst_q <= FS_FAULT;
        FS_FAULT: begin
          if (!fault_cond && (fdctrl_q[FD_MODE] || !fdf_q)) fst_q <= FS_WAIT_UPD;
        end
        FS_WAIT_UPD: begin
          if (fault_cond) fst_q <= FS_FAULT;
          else if (update) fst_q <= FS_IDLE;
        end
        default: fst_q <= FS_IDLE;
      endcase
    end
  end
  assign fault_active = fst_q != FS_IDLE;

  // ----------------------------------------
  // dead-time generators
  // ----------------------------------------
  logic [3:0] wg_prev_q;
  logic [7:0] dt_ls_hs;
  logic [3:0] dten;
  logic [7:0] pairmask;
  assign dten = ctrl_q[3:0];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_dti
      logic [7:0] cnt_q;
      logic wgin;
      assign wgin = ctrl_q[CTRL_CWCM] ? waveform_generator[0] : waveform_generator[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= RST_BYTE;
        end else if (wgin && !wg_prev_q[g]) begin
          cnt_q <= low_side_dead_time_q;
        end else if (!wgin && wg_prev_q[g]) begin
          cnt_q <= high_side_dead_time_q;
        end else if (cnt_q != 8'h00) begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) wg_prev_q[g] <= 1'b0;
        else wg_prev_q[g] <= wgin;
      end
      // low side non-inverted, high side inverted, both off while counting
      assign dt_ls_hs[2*g] = (cnt_q == 8'h00) && wgin && wg_prev_q[g];
      assign dt_ls_hs[2*g+1] = (cnt_q == 8'h00) && !wgin && !wg_prev_q[g];
      assign pairmask[2*g +: 2] = {2{dten[g]}};
    end
  endgenerate

  // ----------------------------------------
  // port override and outputs
  // ----------------------------------------
  logic [7:0] out_d, ovr_d, dir_d, chan_en;
  always_comb begin
    chan_en = {compare_channel_output_enable[3], compare_channel_output_enable[3],
               compare_channel_output_enable[2], compare_channel_output_enable[2],
               compare_channel_output_enable[1], compare_channel_output_enable[1],
               compare_channel_output_enable[0], compare_channel_output_enable[0]};
    if (ctrl_q[CTRL_PGM]) begin
      ovr_d = outov_q;
      out_d = outov_q & {8{waveform_generator[0]}};
      out_d = out_d | (~outov_q & low_side_dead_time_q);
      ovr_d = 8'hff;
    end else begin
      ovr_d = (pairmask & outov_q) | (~pairmask & chan_en);
      out_d = dt_ls_hs;
    end
    dir_d = dirsw_q;
    if (fault_active && fd_enabled) dir_d = dirsw_q & ~pairmask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_out <= RST_BYTE;
      port_override <= RST_BYTE;
      port_dir <= RST_BYTE;
    end else begin
      port_out <= out_d;
      port_override <= ovr_d;
      port_dir <= (fault_cond && fd_enabled) ? (dirsw_q & ~pairmask) : dir_d;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [7:0] rd_d;
  always_comb begin
    case (s_axi_araddr)
      ADDR_CTRL: rd_d = ctrl_q;
      ADDR_FDEMASK: rd_d = fdemask_q;
      ADDR_FDCTRL: rd_d = fdctrl_q;
      ADDR_STATUS: rd_d = {5'h00, fdf_q, hsv_q, lsv_q};
      ADDR_LOW_SIDE_DEAD_TIME: rd_d = low_side_dead_time_q;
      ADDR_HIGH_SIDE_DEAD_TIME: rd_d = high_side_dead_time_q;
      ADDR_DTLSBUF: rd_d = dtlsbuf_q;
      ADDR_DTHSBUF: rd_d = dthsbuf_q;
      ADDR_OUTOV: rd_d = outov_q;
      ADDR_PORTDIR: rd_d = dirsw_q;
      ADDR_LOCK: rd_d = {7'h00, lock_q};
      default: rd_d = RST_BYTE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_d};
        s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_fault_seen;
    fault_cond && fd_enabled;
  endsequence
  AST_FAULT_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    s_fault_seen |=> ((port_dir & pairmask) == 8'h00))
    else $error("direction not cleared after fault");
  AST_FDF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_cond |=> fdf_q && timer_error_flag)
    else $error("fault flag not set");
  AST_DT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (gen_dti[0].cnt_q != 8'h00) |-> !dt_ls_hs[0] && !dt_ls_hs[1])
    else $error("outputs on during dead time");
  AST_DT_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
    (gen_dti[1].cnt_q > 8'h01 && $stable(waveform_generator) && !ctrl_q[CTRL_CWCM]
     && wg_prev_q[1] == waveform_generator[1])
    |=> gen_dti[1].cnt_q == $past(gen_dti[1].cnt_q) - 8'h01)
    else $error("dead-time counter not decrementing");
  AST_RISE_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (waveform_generator[0] && !wg_prev_q[0] && !ctrl_q[CTRL_CWCM])
    |=> gen_dti[0].cnt_q == $past(low_side_dead_time_q))
    else $error("rise did not load low side");
  AST_LOCK_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_q |=> $stable(ctrl_q) && $stable(fdemask_q))
    else $error("locked register changed");
  AST_OUTOV_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_active |=> $stable(outov_q))
    else $error("override changed during fault");
  AST_CBC_RESUME: assert property (@(posedge aclk) disable iff (!aresetn)
    (fst_q == FS_WAIT_UPD && !fault_cond && !update) |=> fst_q == FS_WAIT_UPD)
    else $error("left fault without update");
  AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (fst_q == FS_FAULT && !fdctrl_q[FD_MODE] && fdf_q) |=> fst_q == FS_FAULT)
    else $error("latched fault released with flag set");
  AST_BUF_UPD: assert property (@(posedge aclk) disable iff (!aresetn)
    (lsv_q && !update && !wr_en) |=> $stable(low_side_dead_time_q))
    else $error("active value changed without update");
endmodule : wavext

//--- sim/timer_model.sv
`timescale 1ns/10ps
module timer_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control from bench
  input wire logic run,
  input wire logic upd_req,
  input wire logic [7:0] half_len,
  // timer outputs
  output logic [3:0] wave,
  output logic update
);
  logic [7:0] cnt_q;
  // ----------------------------------------
  // square waveform, all four channels alike
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      wave <= 4'h0;
    end else if (run && cnt_q >= half_len - 8'h01) begin
      cnt_q <= 8'h00;
      wave <= ~wave;
    end else if (run) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // ----------------------------------------
  // one-cycle update at period start or on request
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update <= 1'b0;
    end else begin
      update <= upd_req | (run && cnt_q >= half_len - 8'h01 && !wave[0]);
    end
  end
endmodule : timer_model

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench
  import wavext_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, update, debug_break, terr, run, upd_req;
  logic [7:0] awaddr, araddr, event_in, port_out, port_override, port_dir, half_len, ov;
  logic [31:0] wdata, rdata, seed, d;
  logic [3:0] wstrb, wg, ccen;
  logic [1:0] bresp, rresp, r;
  int failures, tests_run, cyc, overlap, n, dt;
  bit pgm;
  wavext u_wavext (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .waveform_generator(wg), .compare_channel_output_enable(ccen),
    .update(update), .event_in(event_in), .debug_break(debug_break), .port_out(port_out),
    .port_override(port_override), .port_dir(port_dir), .timer_error_flag(terr));
  timer_model u_timer_model (.aclk(aclk), .aresetn(aresetn), .run(run), .upd_req(upd_req),
    .half_len(half_len), .wave(wg), .update(update));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] pins(input logic [3:0] en);
    logic [7:0] m;
    for (int g = 0; g < 4; g++) m[2*g +: 2] = {2{en[g]}};
    return m;
  endfunction : pins
  function automatic logic [7:0] pat_exp(input logic [7:0] o, input logic [7:0] v, input logic a);
    return (o & {8{a}}) | (~o & v);
  endfunction : pat_exp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(bvalid && bready)) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!(rvalid && rready)) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask : rdc
  task automatic fault_chk(input string nm, input logic [7:0] e);
    repeat (3) @(posedge aclk);
    #1;
    chk(nm, e, port_dir);
  endtask : fault_chk
  task automatic upd();
    @(posedge aclk);
    upd_req <= 1'b1;
    @(posedge aclk);
    upd_req <= 1'b0;
  endtask : upd
  task automatic gap(input int g, input logic up);
    n = 0;
    while (wg[g] !== !up) @(posedge aclk);
    while (wg[g] !== up) @(posedge aclk);
    while (port_out[2*g + (up ? 0 : 1)] !== 1'b1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
  endtask : gap
  // ----------------------------------------
  // clock, timeout and overlap watch
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && !pgm)
      for (int g = 0; g < 4; g++)
        if (port_out[2*g] === 1'b1 && port_out[2*g+1] === 1'b1) overlap++;
    if (cyc == 20000) begin
      failures++;
      $display("[FAIL] run time expected done got hang");
      end_sim();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, debug_break, run, upd_req} = '0;
    {awaddr, araddr, event_in, wdata, wstrb} = '0;
    half_len = 8'd48;
    seed = 32'h7e752d15;
    ccen = seed[3:0];
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctrl_rst", ADDR_CTRL, {24'h0, RST_BYTE});
    rdc("status_rst", ADDR_STATUS, {24'h0, RST_BYTE});
    rdc("low_side_dead_time_rst", ADDR_LOW_SIDE_DEAD_TIME, {24'h0, RST_BYTE});
    rd(8'h04);
    chk("rd_unmapped", RESP_SLVERR, r);
    wr(8'h40, 32'h1);
    chk("wr_unmapped", RESP_SLVERR, r);
    chk("dir_rst", 8'h00, port_dir);
    $display("test registers done");
    wr(ADDR_PORTDIR, 32'hff);
    wr(ADDR_CTRL, 32'h0f);
    wr(ADDR_OUTOV, 32'hff);
    run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      dt = 2 + seed[7:0] % 30;
      ccen <= seed[15:12];
      wr(ADDR_LOW_SIDE_DEAD_TIME, dt);
      wr(ADDR_HIGH_SIDE_DEAD_TIME, dt + 3);
      gap(i, 1'b1);
      chk("ls_gap", 1, n >= dt && n <= dt + 4);
      gap(i, 1'b0);
      chk("hs_gap", 1, n >= dt + 3 && n <= dt + 7);
    end
    chk("no_overlap", 0, overlap);
    $display("test dead time done");
    pgm = 1'b1;
    seed = xs(seed);
    ov = seed[7:0];
    wr(ADDR_CTRL, 32'h2f);
    wr(ADDR_LOW_SIDE_DEAD_TIME, seed[15:8]);
    wr(ADDR_OUTOV, ov);
    for (int a = 1; a >= 0; a--) begin
      while (wg[0] === a[0]) @(posedge aclk);
      while (wg[0] !== a[0]) @(posedge aclk);
      repeat (4) @(posedge aclk);
      #1;
      chk("pattern", pat_exp(ov, seed[15:8], a[0]), port_out);
      chk("pat_ovr", 8'hff, port_override);
    end
    run <= 1'b0;
    wr(ADDR_CTRL, 32'h05);
    wr(ADDR_LOW_SIDE_DEAD_TIME, 32'h11);
    wr(ADDR_DTLSBUF, 32'h3c);
    wr(ADDR_DTHSBUF, 32'h5a);
    pgm = 1'b0;
    rdc("low_side_dead_time_before_upd", ADDR_LOW_SIDE_DEAD_TIME, 32'h11);
    rdc("bufv_set", ADDR_STATUS, 32'h3);
    upd();
    rdc("low_side_dead_time_after_upd", ADDR_LOW_SIDE_DEAD_TIME, 32'h3c);
    rdc("high_side_dead_time_after_upd", ADDR_HIGH_SIDE_DEAD_TIME, 32'h5a);
    wr(ADDR_DTBOTHBUF, 32'h27);
    rdc("both_before_upd", ADDR_LOW_SIDE_DEAD_TIME, 32'h3c);
    upd();
    rdc("both_ls", ADDR_LOW_SIDE_DEAD_TIME, 32'h27);
    rdc("both_hs", ADDR_HIGH_SIDE_DEAD_TIME, 32'h27);
    rdc("bufv_clear", ADDR_STATUS, 32'h0);
    repeat (2) @(posedge aclk);
    #1;
    chk("override", (ov & pins(4'h5)) | (pins(ccen) & ~pins(4'h5)), port_override);
    $display("test pattern and buffers done");
    for (int m = 0; m < 2; m++) begin
      seed = xs(seed);
      wr(ADDR_FDEMASK, 32'h1 << seed[2:0]);
      wr(ADDR_FDCTRL, (1 << FD_DBD) | (m << FD_MODE) | FAULT_ACTION_FIELD_CLEARDIR);
      @(posedge aclk);
      event_in <= 8'h01 << seed[2:0];
      fault_chk("dir_fault", 8'hcc);
      chk("err_flag", 1, terr);
      rd(ADDR_STATUS);
      chk("fdf_set", 1, d[ST_FDF]);
      wr(ADDR_OUTOV, 32'h0);
      rdc("outov_kept", ADDR_OUTOV, {24'h0, ov});
      @(posedge aclk);
      event_in <= 8'h00;
      fault_chk("dir_held", 8'hcc);
      if (m == 0) begin
        upd();
        fault_chk("latched_held", 8'hcc);
        wr(ADDR_STATUS, 32'h0);
        rd(ADDR_STATUS);
        chk("fdf_kept", 1, d[ST_FDF]);
        wr(ADDR_STATUS, 32'h4);
      end
      upd();
      fault_chk("dir_restored", 8'hff);
      wr(ADDR_STATUS, 32'h4);
    end
    wr(ADDR_FDEMASK, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_FDCTRL, (k << FD_DBD) | (1 << FD_MODE) | FAULT_ACTION_FIELD_CLEARDIR);
      @(posedge aclk);
      debug_break <= 1'b1;
      fault_chk("dbg_fault", k ? 8'hff : 8'hcc);
      @(posedge aclk);
      debug_break <= 1'b0;
      fault_chk("dbg_held", k ? 8'hff : 8'hcc);
      upd();
      wr(ADDR_STATUS, 32'h4);
    end
    wr(ADDR_FDEMASK, 32'hff);
    for (int a = 0; a < 3; a++) begin
      wr(ADDR_FDCTRL, a);
      @(posedge aclk);
      event_in <= 8'hff;
      fault_chk("no_action", 8'hff);
      @(posedge aclk);
      event_in <= 8'h00;
    end
    $display("test faults done");
    wr(ADDR_LOCK, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_FDEMASK, 32'h55);
    wr(ADDR_OUTOV, 32'h0);
    rdc("ctrl_locked", ADDR_CTRL, 32'h05);
    rdc("mask_locked", ADDR_FDEMASK, 32'hff);
    rdc("outov_locked", ADDR_OUTOV, {24'h0, ov});
    $display("test lock done");
    end_sim();
  end
endmodule : testbench
